// ==== accel_regs_pkg.sv ====
// constants and carrier types for the buffered axis readout register bank
// Operation
// - buffer y low byte gives bits 7:0, or 11:4 under big-endian order
// - buffer y high byte gives bits 11:8, or 3:0 under big-endian order
// - buffer z low and high bytes follow the same byte-order split
// - y skip set makes auto-increment pass over both buffer y registers unless x and z skip are set too
// - z skip set makes auto-increment pass over both buffer z registers unless x and y skip are set too
// - revision register is read-only, two bcd digits major.minor 1.0 to 9.9
// - identity register is read-only and returns a fixed 8-bit product code
// - system mode register is read-only: mode, gate error flag, gate count
// - boot pin low resets mode and config1 to 00h; high to 01h and 03h
// - config1 read-write: range, self-test axis and polarity, soft reset, active
// - config2 read-write: wake/sleep power, byte order, auto-increment, fast read
// - config2 resets to 00h whatever the boot pin level
package accel_regs_pkg;
   localparam logic [7:0] ADDR_BUF_X_LO = 8'h0C;
   localparam logic [7:0] ADDR_BUF_X_HI = 8'h0D;
   localparam logic [7:0] ADDR_BUF_Y_LO = 8'h0E;
   localparam logic [7:0] ADDR_BUF_Y_HI = 8'h0F;
   localparam logic [7:0] ADDR_BUF_Z_LO = 8'h10;
   localparam logic [7:0] ADDR_BUF_Z_HI = 8'h11;
   localparam logic [7:0] ADDR_REVISION = 8'h12;
   localparam logic [7:0] ADDR_IDENTITY = 8'h13;
   localparam logic [7:0] ADDR_OPERATING_STATE_STATUS = 8'h14;
   localparam logic [7:0] ADDR_CONFIG1 = 8'h15;
   localparam logic [7:0] ADDR_CONFIG2 = 8'h16;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h31;
   localparam logic [7:0] MODE_RST_LOW = 8'h00;
   localparam logic [7:0] MODE_RST_HIGH = 8'h01;
   localparam logic [7:0] CONFIG1_RST_LOW = 8'h00;
   localparam logic [7:0] CONFIG1_RST_HIGH = 8'h03;
   localparam logic [7:0] CONFIG2_RST = 8'h00;
   localparam logic [7:0] IRQ_RST = 8'h00;
   localparam int CONFIG1_SRST_BIT = 7;
   localparam int CONFIG2_FREAD_BIT = 0;
   localparam int CONFIG2_AINC_BIT = 1;
   localparam int CONFIG2_ORDER_BIT = 2;
   localparam int IRQ_GATE_ERR_BIT = 0;
   localparam int IRQ_MODE_CHG_BIT = 1;
   localparam int SYNC_STAGES = 2;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } host_req_t;

   typedef struct packed {
      logic [1:0] mode;
      logic gate_err;
      logic [4:0] gate_cnt;
   } sys_state_t;
endpackage

// ==== accel_buffer_readout_regs.sv ====
// register bank for buffered y/z readout, identity, mode and first two configs
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ns
module accel_buffer_readout_regs
   import accel_regs_pkg::*;
#(
   parameter logic [7:0] REVISION_BCD = 8'h10,
   // arbitrary neutral identification value
   parameter logic [7:0] IDENTITY_CODE = 8'h5A,
   parameter int SAMPLE_W = 12
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire host_req_t req,
   output logic [7:0] rdata_q,
   output logic [7:0] next_addr_q,
   input wire logic boot_mode_pin,
   input wire logic [SAMPLE_W-1:0] buf_y_sample,
   input wire logic [SAMPLE_W-1:0] buf_z_sample,
   input wire logic x_axis_skip,
   input wire logic y_axis_skip,
   input wire logic z_axis_skip,
   input wire sys_state_t sys_state,
   output logic [7:0] config1_q,
   output logic [7:0] config2_q,
   output logic byte_order_select,
   output logic fast_read_select,
   output logic irq
);

   initial begin
      if (SAMPLE_W != 12) begin
         $error("sample width must be 12");
      end
      if (REVISION_BCD[7:4] < 4'h1 || REVISION_BCD[7:4] > 4'h9 ||
          REVISION_BCD[3:0] > 4'h9) begin
         $error("revision must be bcd 1.0 to 9.9");
      end
   end

   logic [SYNC_STAGES-1:0] boot_sync_q;
   logic boot_level;
   logic [7:0] operating_state_status_q;
   logic [7:0] operating_state_status_d;
   logic [7:0] irq_status_q;
   logic [7:0] irq_mask_q;
   logic [7:0] irq_events;
   logic [7:0] rdata_d;
   logic [7:0] next_addr_d;
   logic srst_q;

   // boot pin synchroniser
   always_ff @(posedge clk) begin
      boot_sync_q <= {boot_sync_q[SYNC_STAGES-2:0], boot_mode_pin};
   end
   assign boot_level = boot_sync_q[SYNC_STAGES-1];

   function automatic logic [7:0] low_byte(input logic [11:0] s, input logic be);
      return be ? s[11:4] : s[7:0];
   endfunction

   function automatic logic [7:0] high_byte(input logic [11:0] s, input logic be);
      return be ? {4'h0, s[3:0]} : {4'h0, s[11:8]};
   endfunction

   // auto-increment successor of a read address
   function automatic logic [7:0] next_of(input logic [7:0] a, input logic fr,
                                          input logic xs, input logic ys,
                                          input logic zs);
      logic [7:0] n;
      n = a + 8'h01;
      case (a)
         ADDR_BUF_X_HI: begin
            n = !ys ? ADDR_BUF_Y_LO : (!zs ? ADDR_BUF_Z_LO : ADDR_BUF_X_LO);
         end
         ADDR_BUF_Y_LO: begin
            if (fr) begin
               n = !zs ? ADDR_BUF_Z_LO : (!xs ? ADDR_BUF_X_LO : ADDR_BUF_Y_LO);
            end
         end
         ADDR_BUF_Y_HI: begin
            n = !zs ? ADDR_BUF_Z_LO : (!xs ? ADDR_BUF_X_LO : ADDR_BUF_Y_LO);
         end
         ADDR_BUF_Z_LO: begin
            if (fr) begin
               n = !xs ? ADDR_BUF_X_LO : (!ys ? ADDR_BUF_Y_LO : ADDR_BUF_Z_LO);
            end
         end
         ADDR_BUF_Z_HI: begin
            n = !xs ? ADDR_BUF_X_LO : (!ys ? ADDR_BUF_Y_LO : ADDR_BUF_Z_LO);
         end
         default: begin
            n = a + 8'h01;
         end
      endcase
      return n;
   endfunction

   assign byte_order_select = config2_q[CONFIG2_ORDER_BIT];
   assign fast_read_select = config2_q[CONFIG2_FREAD_BIT];

   // config1 with boot-dependent reset and self-clearing soft reset
   always_ff @(posedge clk) begin
      if (sys_rst || srst_q) begin
         config1_q <= boot_level ? CONFIG1_RST_HIGH : CONFIG1_RST_LOW;
      end else if (req.wr && req.addr == ADDR_CONFIG1) begin
         config1_q <= req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         srst_q <= 1'b0;
      end else begin
         srst_q <= req.wr && req.addr == ADDR_CONFIG1 && req.wdata[CONFIG1_SRST_BIT];
      end
   end

   // config2 ignores the boot pin
   always_ff @(posedge clk) begin
      if (sys_rst || srst_q) begin
         config2_q <= CONFIG2_RST;
      end else if (req.wr && req.addr == ADDR_CONFIG2) begin
         config2_q <= req.wdata;
      end
   end

   // system mode follows the live state after reset
   assign operating_state_status_d = {sys_state.gate_cnt, sys_state.gate_err, sys_state.mode};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         operating_state_status_q <= boot_level ? MODE_RST_HIGH : MODE_RST_LOW;
      end else begin
         operating_state_status_q <= operating_state_status_d;
      end
   end

   // sticky events: gate error rise, mode change
   always_comb begin
      irq_events = 8'h00;
      irq_events[IRQ_GATE_ERR_BIT] = operating_state_status_d[2] && !operating_state_status_q[2];
      irq_events[IRQ_MODE_CHG_BIT] = operating_state_status_d[1:0] != operating_state_status_q[1:0];
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_status_q <= IRQ_RST;
      end else if (req.rd && req.addr == ADDR_IRQ_STATUS) begin
         irq_status_q <= irq_events;
      end else begin
         irq_status_q <= irq_status_q | irq_events;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_mask_q <= IRQ_RST;
      end else if (req.wr && req.addr == ADDR_IRQ_MASK) begin
         irq_mask_q <= req.wdata;
      end
   end

   assign irq = |(irq_status_q & irq_mask_q);

   // read mux
   always_comb begin
      rdata_d = 8'h00;
      case (req.addr)
         ADDR_BUF_Y_LO: rdata_d = low_byte(buf_y_sample, byte_order_select);
         ADDR_BUF_Y_HI: rdata_d = high_byte(buf_y_sample, byte_order_select);
         ADDR_BUF_Z_LO: rdata_d = low_byte(buf_z_sample, byte_order_select);
         ADDR_BUF_Z_HI: rdata_d = high_byte(buf_z_sample, byte_order_select);
         ADDR_REVISION: rdata_d = REVISION_BCD;
         ADDR_IDENTITY: rdata_d = IDENTITY_CODE;
         ADDR_OPERATING_STATE_STATUS: rdata_d = operating_state_status_q;
         ADDR_CONFIG1: rdata_d = config1_q;
         ADDR_CONFIG2: rdata_d = config2_q;
         ADDR_IRQ_STATUS: rdata_d = irq_status_q;
         ADDR_IRQ_MASK: rdata_d = irq_mask_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
      end else if (req.rd) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   // auto-increment pointer for multi-byte reads
   assign next_addr_d = next_of(req.addr, fast_read_select, x_axis_skip,
                                y_axis_skip, z_axis_skip);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         next_addr_q <= 8'h00;
      end else if (req.rd) begin
         next_addr_q <= next_addr_d;
      end
   end

   chk_y_low_order: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && req.addr == ADDR_BUF_Y_LO |=> rdata_q ==
      ($past(byte_order_select) ? $past(buf_y_sample[11:4]) : $past(buf_y_sample[7:0])))
      else $error("buffer y low byte wrong");
   chk_y_high_order: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && req.addr == ADDR_BUF_Y_HI |=> rdata_q[7:4] == 4'h0 && rdata_q[3:0] ==
      ($past(byte_order_select) ? $past(buf_y_sample[3:0]) : $past(buf_y_sample[11:8])))
      else $error("buffer y high byte wrong");
   chk_z_low_order: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && req.addr == ADDR_BUF_Z_LO |=> rdata_q ==
      ($past(byte_order_select) ? $past(buf_z_sample[11:4]) : $past(buf_z_sample[7:0])))
      else $error("buffer z low byte wrong");
   chk_y_skip_next: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && y_axis_skip |=> next_addr_q != ADDR_BUF_Y_LO || $past(x_axis_skip && z_axis_skip))
      else $error("skipped y register visited");
   chk_z_skip_next: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && z_axis_skip |=> next_addr_q != ADDR_BUF_Z_LO || $past(x_axis_skip && y_axis_skip))
      else $error("skipped z register visited");
   chk_ident_fixed: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && req.addr == ADDR_IDENTITY |=> rdata_q == IDENTITY_CODE)
      else $error("identity value wrong");
   chk_rev_readonly: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && req.addr == ADDR_REVISION |=> rdata_q == REVISION_BCD)
      else $error("revision value wrong");
   chk_cfg2_reset: assert property (@(posedge clk)
      sys_rst |=> config2_q == CONFIG2_RST)
      else $error("config2 reset value wrong");
   chk_cfg1_boot: assert property (@(posedge clk)
      sys_rst [*3] |=> config1_q == ($past(boot_level) ? CONFIG1_RST_HIGH : CONFIG1_RST_LOW))
      else $error("config1 boot reset wrong");
   chk_fast_wrap: assert property (@(posedge clk) disable iff (sys_rst)
      req.rd && req.addr == ADDR_BUF_Z_LO && fast_read_select && !x_axis_skip
      |=> next_addr_q == ADDR_BUF_X_LO)
      else $error("fast read wrap wrong");
   chk_cfg2_write: assert property (@(posedge clk) disable iff (sys_rst)
      req.wr && req.addr == ADDR_CONFIG2 |=> srst_q || config2_q == $past(req.wdata))
      else $error("config2 write lost");

   cov_fast_burst: cover property (@(posedge clk) disable iff (sys_rst)
      req.rd && fast_read_select && req.addr == ADDR_BUF_Z_LO);
   cov_big_endian: cover property (@(posedge clk) disable iff (sys_rst)
      req.rd && byte_order_select && req.addr == ADDR_BUF_Y_LO);
   cov_irq_raise: cover property (@(posedge clk) disable iff (sys_rst) !irq ##1 irq);

endmodule

// ==== accel_host_model.sv ====
// host side model issuing register writes and reads
`timescale 1ns/1ns
module accel_host_model
   import accel_regs_pkg::*;
(
   input wire logic clk,
   output host_req_t req,
   input wire logic [7:0] rdata_q,
   input wire logic [7:0] next_addr_q
);
   initial req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
   // idle bus shows inverted address and data, strobes low
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [7:0] n);
      req <= '{addr: a, wdata: 8'hA5, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '{addr: ~a, wdata: 8'h5A, wr: 1'b0, rd: 1'b0};
      #1;
      d = rdata_q;
      n = next_addr_q;
      @(posedge clk);
   endtask
endmodule

// ==== accel_buffer_readout_regs_bench.sv ====
// self-checking bench for the buffered readout register bank
`timescale 1ns/1ns
module accel_buffer_readout_regs_bench;
   import accel_regs_pkg::*;
   logic clk, sys_rst, boot_mode_pin, xs, ys, zs, bo, fr, irq;
   logic [11:0] sy, sz;
   logic [7:0] rdata_q, next_addr_q, c1, c2, d, n, v;
   sys_state_t st;
   host_req_t req;
   int failures = 0, check_count = 0, seed = 32'h2992;
   accel_buffer_readout_regs i_accel_buffer_readout_regs (.clk(clk), .sys_rst(sys_rst),
      .req(req), .rdata_q(rdata_q), .next_addr_q(next_addr_q), .boot_mode_pin(boot_mode_pin),
      .buf_y_sample(sy), .buf_z_sample(sz), .x_axis_skip(xs), .y_axis_skip(ys),
      .z_axis_skip(zs), .sys_state(st), .config1_q(c1), .config2_q(c2),
      .byte_order_select(bo), .fast_read_select(fr), .irq(irq));
   accel_host_model i_accel_host_model (.clk(clk), .req(req), .rdata_q(rdata_q),
      .next_addr_q(next_addr_q));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic rst(input logic pin);
      sys_rst <= 1'b1;
      boot_mode_pin <= pin;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
   endtask
   function automatic logic [7:0] bsel(logic [11:0] s, logic o, logic h);
      if (h) return o ? {4'h0, s[3:0]} : {4'h0, s[11:8]};
      return o ? s[11:4] : s[7:0];
   endfunction
   function automatic logic [7:0] nxt(logic [7:0] a, logic f, logic [2:0] s);
      int b;
      if (!(a == 8'h0D || a == 8'h0F || a == 8'h11 || (f && (a == 8'h0E || a == 8'h10))))
         return a + 8'h01;
      b = ((int'(a) - 12) / 2 + 1) % 3;
      for (int k = 0; k < 3; k++)
         if (!s[(b + k) % 3]) return 8'h0C + 8'(2 * ((b + k) % 3));
      return a + 8'h01;
   endfunction
   initial begin
      #(100 * 30000);
      failures++;
      wrap_up();
   end
   initial begin
      sys_rst = 1'b1;
      boot_mode_pin = 1'b0;
      {xs, ys, zs} = 3'b000;
      sy = 12'h000;
      sz = 12'h000;
      st = '0;
      rst(1'b0);
      check(c1, CONFIG1_RST_LOW);
      check(c2, CONFIG2_RST);
      rst(1'b1);
      check(c1, CONFIG1_RST_HIGH);
      check(c2, CONFIG2_RST);
      for (int i = 0; i < 2; i++) begin
         i_accel_host_model.rd(ADDR_REVISION, d, n);
         check(d, 8'h10);
         i_accel_host_model.rd(ADDR_IDENTITY, d, n);
         check(d, 8'h5A);
         i_accel_host_model.wr(ADDR_REVISION, 8'h99);
         i_accel_host_model.wr(ADDR_IDENTITY, 8'hFF);
      end
      for (int i = 0; i < 6; i++) begin
         st <= sys_state_t'($random(seed));
         i_accel_host_model.wr(ADDR_OPERATING_STATE_STATUS, 8'hFF);
         i_accel_host_model.rd(ADDR_OPERATING_STATE_STATUS, d, n);
         check(d, {st.gate_cnt, st.gate_err, st.mode});
         v = 8'($random(seed)) & 8'h7F;
         i_accel_host_model.wr(ADDR_CONFIG1, v);
         i_accel_host_model.rd(ADDR_CONFIG1, d, n);
         check(d, v);
         v = 8'($random(seed));
         i_accel_host_model.wr(ADDR_CONFIG2, v);
         i_accel_host_model.rd(ADDR_CONFIG2, d, n);
         check(d, v);
         check({6'h00, bo, fr}, {6'h00, v[2], v[0]});
      end
      i_accel_host_model.wr(ADDR_CONFIG1, 8'h80);
      repeat (2) @(posedge clk);
      check(c1, CONFIG1_RST_HIGH);
      check(c2, CONFIG2_RST);
      for (int i = 0; i < 12; i++) begin
         sy <= 12'($random(seed));
         sz <= 12'($random(seed));
         i_accel_host_model.wr(ADDR_CONFIG2, {5'h00, i[0], 2'b00});
         for (int a = 14; a < 18; a++) begin
            i_accel_host_model.rd(8'(a), d, n);
            if (a < 16) check(d, bsel(sy, i[0], a[0]));
            else check(d, bsel(sz, i[0], a[0]));
         end
      end
      for (int k = 0; k < 16; k++) begin
         if (k[2:0] != 3'b111) begin
            {zs, ys, xs} <= k[2:0];
            i_accel_host_model.wr(ADDR_CONFIG2, {7'h00, k[3]});
            for (int a = 13; a < 18; a++) begin
               i_accel_host_model.rd(8'(a), d, n);
               check(n, nxt(8'(a), k[3], k[2:0]));
            end
         end
      end
      st <= '0;
      i_accel_host_model.wr(ADDR_IRQ_MASK, 8'h00);
      i_accel_host_model.rd(ADDR_IRQ_STATUS, d, n);
      st.gate_err <= 1'b1;
      repeat (3) @(posedge clk);
      check({7'h00, irq}, 8'h00);
      i_accel_host_model.wr(ADDR_IRQ_MASK, 8'h03);
      check({7'h00, irq}, 8'h01);
      i_accel_host_model.rd(ADDR_IRQ_STATUS, d, n);
      check(d, 8'h01);
      check({7'h00, irq}, 8'h00);
      st.mode <= 2'b01;
      repeat (3) @(posedge clk);
      i_accel_host_model.rd(ADDR_IRQ_STATUS, d, n);
      check(d, 8'h02);
      i_accel_host_model.wr(8'h40, 8'hFF);
      i_accel_host_model.rd(8'h40, d, n);
      check(d, 8'h00);
      wrap_up();
   end
endmodule
